// ==== hdl/bus_cmd_map.vh ====
// bus_cmd_map.vh: constants for the bus command responder (offsets, fields, resets, command bytes)
// assumes a 100 MHz clock and an AHB-Lite slave with 32-bit word registers
// Contract
// (R1) universal clear opens all channels and selects step scan mode
// (R2) power-up and both clears load interval time 000:010 seconds
// (R3) clears load alarm time 00:00:00 with the alarm disabled
// (R4) end flag on the last talk byte is the default setting
// (R5) power-up and clears drive all auxiliary port outputs low
// (R6) default output format is prefixed channel data until reprogrammed
// (R7) clears leave the real-time clock time of day unchanged
// (R8) lockout blocks all front-panel controls except power until cleared
// (R9) lockout only acts while remote enable is asserted low
// (R10) controller polls: attention, enable poll, address talk, release attention
// (R11) poll enabled, talk addressed, attention false: status byte on data lines
// (R12) controller ends poll with attention and poll disable command
// (R13) untalk leaves talk state and stops driving data
// (R14) unlisten leaves listen state
// (R15) addressed commands act only when listen address matches own address
// (R16) controller addresses device to listen before selected clear or trigger
// (R17) selected clear restores defaults and erases program memory
// (R18) selected clear sets relay buffer and display pointers to location 1
// (R19) trigger in start-on-bus-trigger mode starts scan and lights run lamp
// (R20) continuous scan mode repeats the triggered scan sequence
// (R21) universal clear also erases program memory and rewinds relay pointer
// (R22) trigger is accepted without listen addressing
// (R23) go-to-local leaves remote; lockout releases only when remote enable goes high
`ifndef BUS_CMD_MAP_VH
`define BUS_CMD_MAP_VH
// register byte offsets
`define OFS_CTRL      8'h00
`define OFS_CONFIG    8'h04
`define OFS_STATUS    8'h08
`define OFS_INTERVAL  8'h0C
`define OFS_ALARM     8'h10
`define OFS_AUXOUT    8'h14
`define OFS_SERPOLL   8'h18
`define OFS_POINTERS  8'h1C
// control bits (write 1 pulses)
`define CTRL_SCAN_DONE  0
`define CTRL_PROG_WRITE 1
`define CTRL_PANEL_REQ  2
// config fields
`define CFG_ADDR_LSB  0
`define CFG_SCAN_LSB  8
`define CFG_TRIG_LSB  12
`define CFG_EOI_BIT   16
`define CFG_FMT_LSB   20
`define CFG_ALARM_EN  24
// scan program modes
`define SCAN_STEP       2'h0
`define SCAN_SINGLE     2'h1
`define SCAN_CONTINUOUS 2'h2
// trigger modes
`define TRIG_START_BUS  3'h2
`define TRIG_STOP_BUS   3'h3
`define TRIG_START_EXT  3'h6
// output formats
`define FMT_PREFIXED_CHANNEL 5'h00
// reset values
`define RST_INTERVAL  32'h0000_0010
`define RST_ALARM     24'h00_0000
`define RST_AUXOUT    8'h00
`define RST_PROG_ADDR 8'h01
// bus command bytes (attention asserted)
`define CMD_LLO 8'h11
`define CMD_DCL 8'h14
`define CMD_SPE 8'h18
`define CMD_SPD 8'h19
`define CMD_GTL 8'h01
`define CMD_SDC 8'h04
`define CMD_GET 8'h08
`define CMD_UNL 8'h3F
`define CMD_UNT 8'h5F
`define CMD_LAG_BASE 8'h20
`define CMD_TAG_BASE 8'h40
`endif

// ==== hdl/bus_cmd_responder.v ====
// bus_cmd_responder.v: bus command interpreter and register file of the scanner interface
// assumes bus command bytes arrive as one-cycle strobes from an external handshake engine;
// attention and remote enable are raw pins, active low, and are synchronised here
//
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/10ps
`include "bus_cmd_map.vh"
module bus_cmd_responder (
   // clock and reset
   input  wire        I_CLK,
   input  wire        I_RST_B,
   // ahb-lite slave
   input  wire        I_HSEL,
   input  wire [7:0]  I_HADDR,
   input  wire [1:0]  I_HTRANS,
   input  wire        I_HWRITE,
   input  wire [2:0]  I_HSIZE,
   input  wire [31:0] I_HWDATA,
   input  wire        I_HREADY,
   output wire [31:0] O_HRDATA,
   output wire        O_HREADYOUT,
   output wire        O_HRESP,
   // bus lines, raw pins, active low
   input  wire        I_ATN_B,
   input  wire        I_REN_B,
   // received byte from the handshake engine
   input  wire        I_BYTE_VALID,
   input  wire [7:0]  I_BYTE,
   // instrument side
   output reg         O_TALK,
   output reg         O_LISTEN,
   output reg         O_REMOTE,
   output reg         O_LOCKOUT,
   output reg         O_RUN,
   output reg  [7:0]  O_DIO,
   output reg         O_DIO_OE,
   output reg         O_EOI_ON_LAST,
   output reg  [7:0]  O_AUX_OUT,
   output reg         O_CLEAR_PULSE
);
   // synchronisers
   reg  [1:0]  atn_sync;
   reg  [1:0]  ren_sync;
   wire        atn = ~atn_sync[1];
   wire        ren = ~ren_sync[1];
   // state
   reg  [4:0]  my_addr;
   reg         serial_poll;
   reg  [1:0]  scan_mode;
   reg  [2:0]  trig_mode;
   reg  [4:0]  out_format;
   reg         alarm_en;
   reg  [31:0] interval;
   reg  [23:0] alarm_time;
   reg  [7:0]  status_byte;
   reg  [7:0]  relay_ptr;
   reg  [7:0]  display_ptr;
   reg  [7:0]  prog_words;
   reg  [7:0]  chan_closed;
   reg         panel_blocked;
   // ahb address phase capture
   reg         dp_write;
   reg         dp_read;
   reg  [7:0]  dp_addr;
   reg  [31:0] rdata;

   // command decode
   wire        cmd      = I_BYTE_VALID & atn;
   wire        c_dcl    = cmd & (I_BYTE == `CMD_DCL);
   wire        c_llo    = cmd & (I_BYTE == `CMD_LLO);
   wire        c_spe    = cmd & (I_BYTE == `CMD_SPE);
   wire        c_spd    = cmd & (I_BYTE == `CMD_SPD);
   wire        c_unt    = cmd & (I_BYTE == `CMD_UNT);
   wire        c_unl    = cmd & (I_BYTE == `CMD_UNL);
   wire        c_my_lsn = cmd & (I_BYTE == (`CMD_LAG_BASE | {3'h0, my_addr}));
   wire        c_my_tlk = cmd & (I_BYTE == (`CMD_TAG_BASE | {3'h0, my_addr}));
   wire        c_oth_tlk = cmd & (I_BYTE[7:5] == 3'h2) & ~c_my_tlk & ~c_unt;
   wire        c_sdc    = cmd & O_LISTEN & (I_BYTE == `CMD_SDC);  // R15 R16
   wire        c_gtl    = cmd & O_LISTEN & (I_BYTE == `CMD_GTL);  // R15
   wire        c_get    = cmd & (I_BYTE == `CMD_GET);             // R22
   wire        any_clear = c_dcl | c_sdc;
   wire        ahb_go   = I_HSEL & I_HREADY & I_HTRANS[1];

   // two-flop synchronisers on the bus pins
   always @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         atn_sync <= 2'b11;
         ren_sync <= 2'b11;
      end else begin
         atn_sync <= {atn_sync[0], I_ATN_B};
         ren_sync <= {ren_sync[0], I_REN_B};
      end
   end

   // addressing, poll and remote state
   always @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_TALK      <= 1'b0;
         O_LISTEN    <= 1'b0;
         O_REMOTE    <= 1'b0;
         O_LOCKOUT   <= 1'b0;
         serial_poll <= 1'b0;
      end else begin
         if (c_my_tlk)
            O_TALK <= 1'b1;
         else if (c_unt | c_oth_tlk)
            O_TALK <= 1'b0;                     // R13
         if (c_my_lsn)
            O_LISTEN <= 1'b1;
         else if (c_unl)
            O_LISTEN <= 1'b0;                   // R14
         if (c_spe)
            serial_poll <= 1'b1;                // R10
         else if (c_spd)
            serial_poll <= 1'b0;                // R12
         if (!ren)
            O_REMOTE <= 1'b0;
         else if (c_gtl)
            O_REMOTE <= 1'b0;                   // R23
         else if (c_my_lsn)
            O_REMOTE <= 1'b1;
         if (!ren)
            O_LOCKOUT <= 1'b0;                  // R23
         else if (c_llo)
            O_LOCKOUT <= 1'b1;                  // R9
      end
   end

   // front panel gate: power switch is outside this block
   always @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B)
         panel_blocked <= 1'b0;
      else
         panel_blocked <= O_LOCKOUT | O_REMOTE; // R8
   end

   // data line drive during a serial poll
   always @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_DIO    <= 8'h00;
         O_DIO_OE <= 1'b0;
      end else begin
         O_DIO    <= status_byte;
         O_DIO_OE <= serial_poll & O_TALK & ~atn & ~c_unt; // R11 R13
      end
   end

   // settings, defaults on clear; time of day lives elsewhere and is untouched
   always @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         my_addr       <= 5'h12;
         scan_mode     <= `SCAN_STEP;
         trig_mode     <= `TRIG_START_EXT;
         out_format    <= `FMT_PREFIXED_CHANNEL;
         alarm_en      <= 1'b0;
         O_EOI_ON_LAST <= 1'b1;
         interval      <= `RST_INTERVAL;
         alarm_time    <= `RST_ALARM;
         O_AUX_OUT     <= `RST_AUXOUT;
         chan_closed   <= 8'h00;
         status_byte   <= 8'h00;
      end else if (any_clear) begin
         scan_mode     <= `SCAN_STEP;           // R1
         chan_closed   <= 8'h00;                // R1
         trig_mode     <= `TRIG_START_EXT;
         interval      <= `RST_INTERVAL;        // R2
         alarm_time    <= `RST_ALARM;           // R3
         alarm_en      <= 1'b0;                 // R3
         O_EOI_ON_LAST <= 1'b1;                 // R4
         O_AUX_OUT     <= `RST_AUXOUT;          // R5
         out_format    <= `FMT_PREFIXED_CHANNEL; // R6 R7
      end else if (dp_write) begin
         case (dp_addr)
            `OFS_CONFIG: begin
               my_addr       <= I_HWDATA[`CFG_ADDR_LSB+4:`CFG_ADDR_LSB];
               scan_mode     <= I_HWDATA[`CFG_SCAN_LSB+1:`CFG_SCAN_LSB]; // R20
               trig_mode     <= I_HWDATA[`CFG_TRIG_LSB+2:`CFG_TRIG_LSB];
               O_EOI_ON_LAST <= I_HWDATA[`CFG_EOI_BIT];
               out_format    <= {1'b0, I_HWDATA[`CFG_FMT_LSB+3:`CFG_FMT_LSB]}; // top bit shares the alarm enable
               alarm_en      <= I_HWDATA[`CFG_ALARM_EN];
            end
            `OFS_INTERVAL: interval    <= I_HWDATA;
            `OFS_ALARM:    alarm_time  <= I_HWDATA[23:0];
            `OFS_AUXOUT:   O_AUX_OUT   <= I_HWDATA[7:0];
            `OFS_SERPOLL:  status_byte <= I_HWDATA[7:0];
            default:       chan_closed <= chan_closed;
         endcase
      end
   end

   // program memory and pointers
   always @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         prog_words  <= 8'h00;
         relay_ptr   <= `RST_PROG_ADDR;
         display_ptr <= `RST_PROG_ADDR;
      end else if (any_clear) begin
         prog_words <= 8'h00;                   // R17 R21
         relay_ptr  <= `RST_PROG_ADDR;          // R18 R21
         if (c_sdc)
            display_ptr <= `RST_PROG_ADDR;      // R18
      end else if (dp_write && dp_addr == `OFS_CTRL && I_HWDATA[`CTRL_PROG_WRITE]) begin
         prog_words <= prog_words + 8'h01;
         relay_ptr  <= relay_ptr + 8'h01;
      end else if (dp_write && dp_addr == `OFS_POINTERS) begin
         relay_ptr   <= I_HWDATA[7:0];
         display_ptr <= I_HWDATA[15:8];
      end
   end

   // run lamp and scan start; a scan end from software stops all but continuous mode
   always @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_RUN         <= 1'b0;
         O_CLEAR_PULSE <= 1'b0;
      end else begin
         O_CLEAR_PULSE <= any_clear;
         if (any_clear)
            O_RUN <= 1'b0;
         else if (c_get && trig_mode == `TRIG_START_BUS)
            O_RUN <= 1'b1;                      // R19
         else if (c_get && trig_mode == `TRIG_STOP_BUS)
            O_RUN <= 1'b0;
         else if (dp_write && dp_addr == `OFS_CTRL && I_HWDATA[`CTRL_SCAN_DONE])
            O_RUN <= (scan_mode == `SCAN_CONTINUOUS); // R20
      end
   end

   // ahb address phase capture and read mux
   always @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         dp_write <= 1'b0;
         dp_read  <= 1'b0;
         dp_addr  <= 8'h00;
         rdata    <= 32'h0000_0000;
      end else begin
         dp_write <= ahb_go & I_HWRITE;
         dp_read  <= ahb_go & ~I_HWRITE;
         dp_addr  <= {I_HADDR[7:2], 2'b00};
         if (ahb_go && !I_HWRITE) begin
            case ({I_HADDR[7:2], 2'b00})
               `OFS_CONFIG:   rdata <= {7'h00, alarm_en, out_format[3:0], 3'h0, O_EOI_ON_LAST,
                                        1'b0, trig_mode, 2'h0, scan_mode, 3'h0, my_addr};
               `OFS_STATUS:   rdata <= {24'h0000_00, panel_blocked, O_RUN, serial_poll,
                                        O_LOCKOUT, O_REMOTE, ren, O_LISTEN, O_TALK};
               `OFS_INTERVAL: rdata <= interval;
               `OFS_ALARM:    rdata <= {8'h00, alarm_time};
               `OFS_AUXOUT:   rdata <= {24'h0000_00, O_AUX_OUT};
               `OFS_SERPOLL:  rdata <= {24'h0000_00, status_byte};
               `OFS_POINTERS: rdata <= {8'h00, prog_words, display_ptr, relay_ptr};
               default:       rdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign O_HRDATA    = dp_read ? rdata : 32'h0000_0000;
   assign O_HREADYOUT = 1'b1;
   assign O_HRESP     = 1'b0;

endmodule // bus_cmd_responder

// ==== testbench/bus_cmd_responder_props.sv ====
// bus_cmd_responder_props.sv: concurrent checks on the command responder ports
// assumes the byte engine strobes bytes and attention, remote enable are raw pins
`timescale 1ns/10ps
`include "bus_cmd_map.vh"
module bus_cmd_responder_props (
   // clock and reset
   input wire logic       I_CLK,
   input wire logic       I_RST_B,
   // bus side inputs
   input wire logic       I_ATN_B,
   input wire logic       I_REN_B,
   input wire logic       I_BYTE_VALID,
   input wire logic [7:0] I_BYTE,
   // watched outputs
   input wire logic       O_HREADYOUT,
   input wire logic       O_HRESP,
   input wire logic       O_TALK,
   input wire logic       O_LISTEN,
   input wire logic       O_LOCKOUT,
   input wire logic       O_DIO_OE,
   input wire logic [7:0] O_AUX_OUT,
   input wire logic       O_EOI_ON_LAST,
   input wire logic       O_CLEAR_PULSE
);
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_B);
   // a byte taken with attention settled low or high
   sequence cmd_seen(logic [7:0] code);
      I_BYTE_VALID && I_BYTE == code && !I_ATN_B && !$past(I_ATN_B) && !$past(I_ATN_B, 2) && !$past(I_ATN_B, 3);
   endsequence
   sequence data_seen(logic [7:0] code);
      I_BYTE_VALID && I_BYTE == code && I_ATN_B && $past(I_ATN_B) && $past(I_ATN_B, 2) && $past(I_ATN_B, 3);
   endsequence
   chk_bus_okay: assert property (O_HREADYOUT && !O_HRESP) else $error("bus answer not ready okay");
   chk_unl_listen: assert property (cmd_seen(`CMD_UNL) |-> ##[1:2] !O_LISTEN) else $error("listen kept");
   chk_unt_talk: assert property (cmd_seen(`CMD_UNT) |-> ##[1:2] (!O_TALK && !O_DIO_OE)) else $error("talk kept");
   chk_dcl_pulse: assert property (cmd_seen(`CMD_DCL) |-> ##[1:2] O_CLEAR_PULSE) else $error("clear missed");
   chk_data_ignored: assert property (data_seen(`CMD_DCL) |-> ##[1:2] !O_CLEAR_PULSE) else $error("data cleared");
   chk_clear_defaults: assert property (O_CLEAR_PULSE |-> ##[0:1] (O_AUX_OUT == 8'h00 && O_EOI_ON_LAST))
      else $error("clear defaults wrong");
   chk_poll_release: assert property ($fell(I_ATN_B) |-> ##[1:4] !O_DIO_OE) else $error("data lines held");
   chk_poll_talk: assert property (O_DIO_OE |-> O_TALK) else $error("driving while not talker");
   chk_lock_ren: assert property ($rose(O_LOCKOUT) |-> $past(I_REN_B, 3) == 1'h0) else $error("lockout without ren");
   chk_lock_hold: assert property ($fell(O_LOCKOUT) |-> $past(I_REN_B, 3)) else $error("lockout dropped early");
endmodule // bus_cmd_responder_props
bind bus_cmd_responder bus_cmd_responder_props u_props (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_ATN_B(I_ATN_B),
   .I_REN_B(I_REN_B), .I_BYTE_VALID(I_BYTE_VALID), .I_BYTE(I_BYTE), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP),
   .O_TALK(O_TALK), .O_LISTEN(O_LISTEN), .O_LOCKOUT(O_LOCKOUT), .O_DIO_OE(O_DIO_OE), .O_AUX_OUT(O_AUX_OUT),
   .O_EOI_ON_LAST(O_EOI_ON_LAST), .O_CLEAR_PULSE(O_CLEAR_PULSE));

// ==== testbench/bus_controller_model.sv ====
// bus_controller_model.sv: system controller driving attention, remote enable and bytes
// assumes the responder synchronises both pins, so levels act on the third edge and show on the fourth
`timescale 1ns/10ps
module bus_controller_model (
   input  wire logic       i_clk,
   output logic            o_atn_b,
   output logic            o_ren_b,
   output logic            o_valid,
   output logic [7:0]      o_byte
);
   // idle bus, nothing asserted
   initial begin
      o_atn_b = 1'h1;
      o_ren_b = 1'h1;
      o_valid = 1'h0;
      o_byte = 8'h00;
   end
   // attention level, held until the responder has seen it
   task set_atn(input logic v);
      @(posedge i_clk) o_atn_b <= v;
      repeat (4) @(posedge i_clk);
   endtask
   // remote enable level, held until the responder has seen it
   task set_ren(input logic v);
      @(posedge i_clk) o_ren_b <= v;
      repeat (4) @(posedge i_clk);
   endtask
   // one byte strobe, lines scrambled once released
   task send(input logic [7:0] b);
      @(posedge i_clk);
      o_valid <= 1'h1;
      o_byte <= b;
      @(posedge i_clk);
      o_valid <= 1'h0;
      o_byte <= ~b;
      repeat (2) @(posedge i_clk);
   endtask
endmodule // bus_controller_model

// ==== testbench/gpib_bus_command_responder_bench.sv ====
// gpib_bus_command_responder_bench.sv: self-checking bench for the command responder
// assumes a zero-wait slave and own primary address 0x12 after reset
`timescale 1ns/10ps
`include "bus_cmd_map.vh"
module gpib_bus_command_responder_bench;
   logic        I_CLK, I_RST_B, hsel, hwrite;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   wire         hresp, clrp;
   integer      clr_n = 0;
   logic [7:0]  haddr;
   logic [31:0] hwdata, rd, v;
   wire  [31:0] hrdata;
   wire  [7:0]  bval, dio, aux;
   wire         hready, atn_b, ren_b, bvalid, talk, listen, remote, lockout, run, dio_oe, eoi;
   integer      fail_count, checks, n;
   bus_controller_model ctl (.i_clk(I_CLK), .o_atn_b(atn_b), .o_ren_b(ren_b), .o_valid(bvalid), .o_byte(bval));
   bus_cmd_responder DUT (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
      .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
      .O_HREADYOUT(hready), .O_HRESP(hresp), .I_ATN_B(atn_b), .I_REN_B(ren_b), .I_BYTE_VALID(bvalid), .I_BYTE(bval),
      .O_TALK(talk), .O_LISTEN(listen), .O_REMOTE(remote), .O_LOCKOUT(lockout), .O_RUN(run), .O_DIO(dio),
      .O_DIO_OE(dio_oe), .O_EOI_ON_LAST(eoi), .O_AUX_OUT(aux), .O_CLEAR_PULSE(clrp));
   // count clear pulses as they stand for one cycle
   always @(posedge I_CLK) if (clrp === 1'h1) clr_n <= clr_n + 1;
   // 100 MHz clock
   initial begin
      I_CLK = 1'h0;
      forever #5 I_CLK = ~I_CLK;
   end
   // expected configuration word with own address and end flag set
   function logic [31:0] cfg(input logic [1:0] scan, input logic [2:0] trig);
      cfg = {15'h0000, 1'h1, 1'h0, trig, 2'h0, scan, 8'h12};
   endfunction
   task print_verdict;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   // single word transfer, read data taken at the data phase edge
   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      hsize <= 3'h2;
      n = 0;
      do begin @(posedge I_CLK); n++; end while (hready !== 1'h1 && n < 40);
      htrans <= 2'h0;
      hwdata <= wd;
      do begin @(posedge I_CLK); n++; end while (hready !== 1'h1 && n < 80);
      rd = hrdata;
      if (n >= 80) begin fail_count++; print_verdict; end
      check("hresp", 0, hresp);
   endtask
   task rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
      ahb(1'h0, a, 32'h0000_0000);
      check(name, exp, rd);
   endtask
   // main sequence
   initial begin
      fail_count = 0;
      checks = 0;
      I_RST_B = 1'h0;
      {hsel, hwrite, htrans, haddr, hwdata, hsize} = '0;
      void'($urandom(71));
      repeat (5) @(posedge I_CLK);
      I_RST_B <= 1'h1;
      repeat (2) @(posedge I_CLK);
      check("eoi", 1, eoi);
      rdchk("config", `OFS_CONFIG, cfg(2'h0, 3'h6));
      rdchk("interval", `OFS_INTERVAL, `RST_INTERVAL);
      rdchk("alarm", `OFS_ALARM, 0);
      rdchk("unmapped", 8'h40, 0);
      $display("reset test done");
      v = ($urandom % 255) + 1;
      ahb(1'h1, `OFS_AUXOUT, v);
      ahb(1'h1, `OFS_ALARM, 32'h0001_0203);
      ctl.send(`CMD_DCL);
      check("aux data", v, {24'h00_0000, aux});
      ctl.set_atn(1'h0);
      ctl.send(`CMD_DCL);
      check("aux clear", 0, {24'h00_0000, aux});
      rdchk("alarm clear", `OFS_ALARM, 0);
      ahb(1'h1, `OFS_AUXOUT, v);
      ctl.send(`CMD_SDC);
      ctl.send(`CMD_LAG_BASE | 8'h0C);
      ctl.send(`CMD_SDC);
      check("aux sdc other", v, {24'h00_0000, aux});
      ctl.send(`CMD_LAG_BASE | 8'h12);
      ctl.send(`CMD_SDC);
      check("aux sdc", 0, {24'h00_0000, aux});
      rdchk("pointers", `OFS_POINTERS, 32'h0000_0101);
      check("clears", 2, clr_n);
      $display("clear test done");
      ctl.send(`CMD_LLO);
      check("lock ren high", 0, lockout);
      ctl.set_ren(1'h0);
      ctl.send(`CMD_LAG_BASE | 8'h12);
      ctl.send(`CMD_LLO);
      check("lock", 1, lockout);
      ctl.send(`CMD_GTL);
      check("remote", 0, remote);
      check("lock kept", 1, lockout);
      ctl.set_ren(1'h1);
      check("unlock", 0, lockout);
      $display("lockout test done");
      v = $urandom % 256;
      ahb(1'h1, `OFS_SERPOLL, v);
      ctl.send(`CMD_SPE);
      ctl.send(`CMD_TAG_BASE | 8'h12);
      ctl.set_atn(1'h1);
      n = 0;
      while (dio_oe !== 1'h1 && n < 20) begin @(posedge I_CLK); n++; end
      check("poll oe", 1, dio_oe);
      check("status", v, {24'h00_0000, dio});
      ctl.set_atn(1'h0);
      ctl.send(`CMD_SPD);
      ctl.send(`CMD_UNT);
      check("talk", 0, {talk, dio_oe});
      rdchk("status", `OFS_STATUS, 32'h0000_0002);
      $display("poll test done");
      ahb(1'h1, `OFS_CONFIG, cfg(2'h2, 3'h2));
      ctl.send(`CMD_UNL);
      check("listen", 0, listen);
      ctl.send(`CMD_GET);
      check("run", 1, run);
      ahb(1'h1, `OFS_CTRL, 32'h0000_0001);
      repeat (2) @(posedge I_CLK);
      check("run again", 1, run);
      ahb(1'h1, `OFS_CONFIG, cfg(2'h0, 3'h2));
      ahb(1'h1, `OFS_CTRL, 32'h0000_0001);
      repeat (2) @(posedge I_CLK);
      check("run step", 0, run);
      $display("trigger test done");
      print_verdict;
   end
endmodule // gpib_bus_command_responder_bench
